// ==== verilog/ussm_pkg.sv ====
/*
 status flag and interrupt mask package for the serial controller status block.
 assumes a word-addressed register port with byte offsets; one 25 MHz clock.
*/
package ussm_pkg;
	localparam logic [31:0] OFS_IER = 32'hfff8_c008;
	localparam logic [31:0] OFS_IDR = 32'hfff8_c00c;
	localparam logic [31:0] OFS_IMR = 32'hfff8_c010;
	localparam logic [31:0] OFS_CSR = 32'hfff8_c014;
	localparam logic [31:0] MASK_VALID = 32'h3f08_ffff;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [3:0] MODE_LIN_MASTER = 4'ha;
	localparam logic [3:0] MODE_LIN_SLAVE = 4'hb;
	localparam logic [3:0] MODE_SPI_SLAVE = 4'hf;
	localparam int B_RX_CHAR_READY = 0;
	localparam int B_TX_HOLDING_FREE = 1;
	localparam int B_BRK = 2;
	localparam int B_RXDONE = 3;
	localparam int B_TXDONE = 4;
	localparam int B_OVR = 5;
	localparam int B_FRM = 6;
	localparam int B_PAR = 7;
	localparam int B_TMO = 8;
	localparam int B_TXEMP = 9;
	localparam int B_REP = 10;
	localparam int B_TXBE = 11;
	localparam int B_RXBF = 12;
	localparam int B_NKBK = 13;
	localparam int B_LID = 14;
	localparam int B_LTC = 15;
	localparam int B_CTSC = 19;
	localparam int B_CTS = 23;
	localparam int B_MAN = 24;
	localparam int B_LBE = 25;
	localparam int B_LSF = 26;
	localparam int B_LIP = 27;
	localparam int B_LCE = 28;
	localparam int B_LSN = 29;
endpackage : ussm_pkg

// ==== verilog/ussm_sticky_if.sv ====
/*
 carrier for the sticky flag cells: shared clear terms.
 assumes one clock domain.
*/
`timescale 1ns/10ps
interface ussm_sticky_if;
	logic clr_sta;
	logic clr_nack;
	modport src (output clr_sta, output clr_nack);
	modport dst (input clr_sta, input clr_nack);
endinterface : ussm_sticky_if

// ==== verilog/ussm_sticky.sv ====
/*
 one sticky flag cell; set wins over clear.
 assumes synchronous set and clear pulses.
*/
`timescale 1ns/10ps
module ussm_sticky (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// control
	input wire logic set,
	input wire logic clr,
	// state
	output logic flag
);
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			flag <= 1'b0;
		else if (set)
			flag <= 1'b1;
		else if (clr)
			flag <= 1'b0;
	end
endmodule : ussm_sticky

// ==== verilog/ussm_status.sv ====
/*
 status flags, mask register and interrupt line of the serial controller.
 assumes event inputs are one-cycle pulses synchronous to sys_clk and the
 register port strobes are one cycle, read data valid the cycle after.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
module ussm_status
	import ussm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// commands and mode
	input wire logic reset_status_cmd,
	input wire logic reset_nonack_cmd,
	input wire logic start_break_cmd,
	input wire logic start_timeout_cmd,
	input wire logic [3:0] usart_mode,
	input wire logic timeout_value_zero,
	// receiver
	input wire logic rx_enabled,
	input wire logic rx_char_done,
	input wire logic rx_busy,
	input wire logic receive_holding_read,
	input wire logic rx_break_evt,
	input wire logic rx_overrun_evt,
	input wire logic rx_stop_low_evt,
	input wire logic rx_parity_evt,
	input wire logic rx_timeout_evt,
	// transmitter
	input wire logic tx_enabled,
	input wire logic transmit_holding_full,
	input wire logic tx_shift_busy,
	input wire logic break_pending,
	// protocol events
	input wire logic max_repeat_evt,
	input wire logic spi_underrun_evt,
	input wire logic nack_evt,
	input wire logic lin_break_evt,
	input wire logic lin_id_evt,
	input wire logic lin_done_evt,
	input wire logic manchester_evt,
	input wire logic [4:0] lin_fault_evt,
	// dma channel signals
	input wire logic rx_dma_done,
	input wire logic tx_dma_done,
	input wire logic tx_dma_buffer_empty,
	input wire logic rx_dma_buffer_full,
	// pins
	input wire logic cts_in,
	// interrupt
	output logic irq
);
	ussm_sticky_if clr_bus ();
	logic [31:0] interrupt_mask_view;
	logic [31:0] channel_status;
	logic rx_char_ready;
	logic rx_cut;
	logic tx_holding_free;
	logic tx_fully_drained;
	logic cts_prev;
	logic cts_primed;
	logic clear_to_send_changed;
	logic is_lin;
	logic csr_read;
	// sticky flags, one latch each, plus the unlatched bit 13 select
	logic break_seen;
	logic overrun_flag;
	logic framing_fault;
	logic parity_fault;
	logic timeout_flag;
	logic max_repeats_hit;
	logic lin_break_flag;
	logic identifier_event;
	logic lin_transfer_done;
	logic manchester_fault;
	logic lin_bit_fault;
	logic sync_field_mismatch;
	logic identifier_parity_fault;
	logic checksum_fault;
	logic slave_silent_fault;
	logic nonack_flag;
	logic nonack_or_break_event;

	assign clr_bus.clr_sta = reset_status_cmd;
	assign clr_bus.clr_nack = reset_nonack_cmd;
	assign is_lin = (usart_mode == MODE_LIN_MASTER) || (usart_mode == MODE_LIN_SLAVE);
	assign csr_read = reg_rd && (reg_addr == OFS_CSR);
	// a start-break command counts as pending in its own cycle, before the transmitter answers
	assign tx_holding_free = tx_enabled && !transmit_holding_full && !break_pending && !start_break_cmd;
	assign tx_fully_drained = tx_enabled && !transmit_holding_full && !tx_shift_busy;
	// bit 13 shows the nack latch outside LIN and the break latch inside it
	assign nonack_or_break_event = is_lin ? lin_break_flag : nonack_flag;

	// receive ready and the memory of a cut reception
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_cut <= 1'b0;
		else if (!rx_enabled && rx_busy)
			rx_cut <= 1'b1;
		else if (rx_enabled)
			rx_cut <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_char_ready <= 1'b0;
		else if (rx_enabled && (rx_char_done || rx_cut))
			rx_char_ready <= 1'b1;
		else if (receive_holding_read || !rx_enabled)
			rx_char_ready <= 1'b0;
	end

	// receiver flags, cleared by reset-status
	ussm_sticky u_break (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(rx_break_evt),
		.clr(clr_bus.clr_sta),
		.flag(break_seen)
	);

	ussm_sticky u_overrun (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(rx_overrun_evt),
		.clr(clr_bus.clr_sta),
		.flag(overrun_flag)
	);

	ussm_sticky u_framing (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(rx_stop_low_evt),
		.clr(clr_bus.clr_sta),
		.flag(framing_fault)
	);

	ussm_sticky u_parity (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(rx_parity_evt),
		.clr(clr_bus.clr_sta),
		.flag(parity_fault)
	);

	// time-out flag: only start-timeout clears it; a zero time-out value keeps it off
	ussm_sticky u_timeout (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(rx_timeout_evt && !timeout_value_zero),
		.clr(start_timeout_cmd),
		.flag(timeout_flag)
	);

	// bit 10 flags the repetition limit, or underruns while in spi slave mode
	ussm_sticky u_repeat (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set((usart_mode == MODE_SPI_SLAVE) ? spi_underrun_evt : max_repeat_evt),
		.clr(clr_bus.clr_sta),
		.flag(max_repeats_hit)
	);

	// LIN events; the break latch is kept apart from the nack latch
	ussm_sticky u_lin_break (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(is_lin && lin_break_evt),
		.clr(clr_bus.clr_sta),
		.flag(lin_break_flag)
	);

	ussm_sticky u_lin_id (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(lin_id_evt),
		.clr(clr_bus.clr_sta),
		.flag(identifier_event)
	);

	ussm_sticky u_lin_done (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(lin_done_evt),
		.clr(clr_bus.clr_sta),
		.flag(lin_transfer_done)
	);

	// manchester decoder error
	ussm_sticky u_manchester (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(manchester_evt),
		.clr(clr_bus.clr_sta),
		.flag(manchester_fault)
	);

	// LIN errors, status bits 25 up to 29
	ussm_sticky u_lin_bit (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(lin_fault_evt[0]),
		.clr(clr_bus.clr_sta),
		.flag(lin_bit_fault)
	);

	ussm_sticky u_sync_field (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(lin_fault_evt[1] && (usart_mode == MODE_LIN_SLAVE)),
		.clr(clr_bus.clr_sta),
		.flag(sync_field_mismatch)
	);

	ussm_sticky u_id_parity (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(lin_fault_evt[2]),
		.clr(clr_bus.clr_sta),
		.flag(identifier_parity_fault)
	);

	ussm_sticky u_checksum (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(lin_fault_evt[3]),
		.clr(clr_bus.clr_sta),
		.flag(checksum_fault)
	);

	ussm_sticky u_slave_silent (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(lin_fault_evt[4]),
		.clr(clr_bus.clr_sta),
		.flag(slave_silent_fault)
	);

	// non-acknowledge outside LIN, only reset-nonack clears
	ussm_sticky u_nack (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set(!is_lin && nack_evt),
		.clr(clr_bus.clr_nack),
		.flag(nonack_flag)
	);

	// cts change detect, cleared by status read with set winning;
	// the first edge after reset only loads the image, so a line idling high raises no change
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cts_prev <= 1'b0;
		else
			cts_prev <= cts_in;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cts_primed <= 1'b0;
		else
			cts_primed <= 1'b1;
	end

	// a change in the very first cycle after reset is not seen
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			clear_to_send_changed <= 1'b0;
		else if (cts_primed && (cts_in != cts_prev))
			clear_to_send_changed <= 1'b1;
		else if (csr_read)
			clear_to_send_changed <= 1'b0;
	end

	// channel status assembly
	always_comb
	begin
		channel_status = '0;
		channel_status[B_RX_CHAR_READY] = rx_char_ready;
		channel_status[B_TX_HOLDING_FREE] = tx_holding_free;
		channel_status[B_BRK] = break_seen;
		channel_status[B_RXDONE] = rx_dma_done;
		channel_status[B_TXDONE] = tx_dma_done;
		channel_status[B_OVR] = overrun_flag;
		channel_status[B_FRM] = framing_fault;
		channel_status[B_PAR] = parity_fault;
		channel_status[B_TMO] = timeout_flag && !timeout_value_zero;
		channel_status[B_TXEMP] = tx_fully_drained;
		channel_status[B_REP] = max_repeats_hit;
		channel_status[B_TXBE] = tx_dma_buffer_empty;
		channel_status[B_RXBF] = rx_dma_buffer_full;
		channel_status[B_NKBK] = nonack_or_break_event;
		channel_status[B_LID] = identifier_event;
		channel_status[B_LTC] = lin_transfer_done;
		channel_status[B_CTSC] = clear_to_send_changed;
		channel_status[B_CTS] = cts_in;
		channel_status[B_MAN] = manchester_fault;
		channel_status[B_LBE] = lin_bit_fault;
		channel_status[B_LSF] = sync_field_mismatch;
		channel_status[B_LIP] = identifier_parity_fault;
		channel_status[B_LCE] = checksum_fault;
		channel_status[B_LSN] = slave_silent_fault;
	end

	// mask set and clear through write-only ports
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			interrupt_mask_view <= MASK_RESET;
		else if (reg_wr && reg_addr == OFS_IER)
			interrupt_mask_view <= interrupt_mask_view | (reg_wdata & MASK_VALID);
		else if (reg_wr && reg_addr == OFS_IDR)
			interrupt_mask_view <= interrupt_mask_view & ~reg_wdata;
	end

	// read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= '0;
		else if (reg_rd && reg_addr == OFS_IMR)
			reg_rdata <= interrupt_mask_view;
		else if (csr_read)
			reg_rdata <= channel_status;
		else
			reg_rdata <= '0;
	end

	// registered, so the line trails a flag or mask change by one cycle
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(channel_status & interrupt_mask_view);
	end
endmodule : ussm_status

// ==== verif/ussm_status_assertions.sv ====
/*
 port checker for the status block.
 assumes one clock and one-cycle event pulses.
*/
`timescale 1ns/10ps
module ussm_status_chk
	import ussm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// register port
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// commands, events and pins
	input wire logic reset_status_cmd,
	input wire logic reset_nonack_cmd,
	input wire logic [3:0] usart_mode,
	input wire logic rx_overrun_evt,
	input wire logic rx_parity_evt,
	input wire logic nack_evt,
	input wire logic rx_dma_done,
	input wire logic cts_in,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	logic ier_seen;
	wire rd_csr = reg_rd && reg_addr == OFS_CSR;
	wire rd_imr = reg_rd && reg_addr == OFS_IMR;
	// irq may only follow a mask bit set by an enable write
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ier_seen <= 1'b0;
		else if (reg_wr && reg_addr == OFS_IER && (reg_wdata & MASK_VALID) != 0)
			ier_seen <= 1'b1;
	end
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data not idle");
	mask_set_a: assert property (
		reg_wr && reg_addr == OFS_IER ##1 !reg_wr ##1 rd_imr
		|=> (reg_rdata & $past(reg_wdata, 3) & MASK_VALID) == ($past(reg_wdata, 3) & MASK_VALID))
		else $error("enable write lost");
	mask_clr_a: assert property (
		reg_wr && reg_addr == OFS_IDR ##1 !reg_wr ##1 rd_imr |=> (reg_rdata & $past(reg_wdata, 3)) == 0)
		else $error("disable write lost");
	irq_cause_a: assert property (irq |-> ier_seen) else $error("irq without mask");
	ovr_hold_a: assert property (
		rx_overrun_evt ##1 !reset_status_cmd ##1 rd_csr |=> reg_rdata[B_OVR]) else $error("overrun lost");
	sta_clr_a: assert property (
		reset_status_cmd && !rx_parity_evt ##1 !rx_parity_evt ##1 rd_csr |=> !reg_rdata[B_PAR])
		else $error("parity not cleared");
	nack_clr_a: assert property (
		reset_nonack_cmd && !nack_evt ##1 !nack_evt ##1 rd_csr && usart_mode < 4'ha |=> !reg_rdata[B_NKBK])
		else $error("nack not cleared");
	mirror_a: assert property (
		rd_csr && $stable(cts_in) && $stable(rx_dma_done)
		|=> reg_rdata[B_CTS] == $past(cts_in) && reg_rdata[B_RXDONE] == $past(rx_dma_done))
		else $error("mirror mismatch");
endmodule : ussm_status_chk
bind ussm_status ussm_status_chk chk (.*);

// ==== verif/ussm_far_node.sv ====
/*
 far side model: dma channel levels and the remote cts line.
 assumes the bench changes req just after a clock edge.
*/
`timescale 1ns/10ps
module ussm_far_node (
	// reset and requested state
	input wire logic rst_n,
	input wire logic [4:0] req,
	// dma channel levels and remote cts
	output logic rx_dma_done,
	output logic tx_dma_done,
	output logic tx_dma_buffer_empty,
	output logic rx_dma_buffer_full,
	output logic cts_in
);
	// channels inactive and cts low while in reset
	assign {cts_in, rx_dma_buffer_full, tx_dma_buffer_empty, tx_dma_done, rx_dma_done} = rst_n ? req : 5'h00;
endmodule : ussm_far_node

// ==== verif/tb.sv ====
/*
 self-checking bench for the status block.
 assumes read data stands in the cycle after the read strobe.
*/
`timescale 1ns/10ps
module tb
	import ussm_pkg::*;
;
	logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
	logic [3:0] usart_mode = '0;
	logic [22:0] ev = '0;
	logic [6:0] lv = '0;
	logic [4:0] req = '0;
	logic rx_dma_done, tx_dma_done, tx_dma_buffer_empty, rx_dma_buffer_full, cts_in, irq;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	ussm_far_node far (.*);
	ussm_status uut (.*, .rx_char_done(ev[0]), .receive_holding_read(ev[1]), .rx_break_evt(ev[2]),
		.rx_overrun_evt(ev[3]), .rx_stop_low_evt(ev[4]), .rx_parity_evt(ev[5]), .rx_timeout_evt(ev[6]),
		.max_repeat_evt(ev[7]), .spi_underrun_evt(ev[8]), .nack_evt(ev[9]), .lin_break_evt(ev[10]),
		.lin_id_evt(ev[11]), .lin_done_evt(ev[12]), .manchester_evt(ev[13]), .reset_status_cmd(ev[14]),
		.reset_nonack_cmd(ev[15]), .start_break_cmd(ev[16]), .start_timeout_cmd(ev[17]),
		.lin_fault_evt(ev[22:18]), .rx_enabled(lv[0]), .rx_busy(lv[1]), .tx_enabled(lv[2]),
		.transmit_holding_full(lv[3]), .tx_shift_busy(lv[4]), .break_pending(lv[5]), .timeout_value_zero(lv[6]));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read, mask and compare
	task automatic rc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, reg_rdata & m, e);
	endtask : rc
	task automatic pl(input int i);
		@(posedge sys_clk);
		ev[i] <= 1'b1;
		@(posedge sys_clk);
		ev[i] <= 1'b0;
	endtask : pl
	task automatic s_mask();
		wr(OFS_IER, 32'hffff_ffff);
		rc(OFS_IMR, '1, MASK_VALID, "imr set");
		wr(OFS_IDR, 32'h0000_00ff);
		rc(OFS_IMR, '1, MASK_VALID & 32'hffff_ff00, "imr clr");
		wr(OFS_IER, 32'h0000_0000);
		wr(OFS_IMR, 32'h0000_0000);
		rc(OFS_IMR, '1, MASK_VALID & 32'hffff_ff00, "imr ro");
		rc(32'hfff8_c030, '1, '0, "unmapped");
	endtask : s_mask
	task automatic s_sticky();
		int ei[15] = '{2, 3, 4, 5, 6, 7, 10, 11, 12, 13, 18, 19, 20, 21, 22};
		int fb[15] = '{2, 5, 6, 7, 8, 10, 13, 14, 15, 24, 25, 26, 27, 28, 29};
		@(posedge sys_clk);
		usart_mode <= MODE_LIN_SLAVE;
		foreach (ei[i])
		begin
			pl(ei[i]);
			rc(OFS_CSR, 32'h1 << fb[i], 32'h1 << fb[i], "flag set");
			pl(fb[i] == B_TMO ? 17 : 14);
			rc(OFS_CSR, 32'h1 << fb[i], '0, "flag clr");
		end
	endtask : s_sticky
	task automatic s_modes();
		@(posedge sys_clk);
		usart_mode <= 4'h0;
		pl(9);
		pl(14);
		rc(OFS_CSR, 32'h0000_2000, 32'h0000_2000, "nack hold");
		pl(15);
		rc(OFS_CSR, 32'h0000_2000, '0, "nack clr");
		@(posedge sys_clk);
		usart_mode <= MODE_SPI_SLAVE;
		pl(8);
		rc(OFS_CSR, 32'h0000_0400, 32'h0000_0400, "underrun");
		@(posedge sys_clk);
		usart_mode <= MODE_LIN_MASTER;
		pl(19);
		rc(OFS_CSR, 32'h0400_0400, 32'h0000_0400, "sync master");
		pl(14);
	endtask : s_modes
	task automatic s_rxtx();
		@(posedge sys_clk);
		lv <= 7'h05;
		pl(0);
		rc(OFS_CSR, 32'h0000_0203, 32'h0000_0203, "ready");
		pl(1);
		rc(OFS_CSR, 32'h0000_0001, '0, "rx read");
		@(posedge sys_clk);
		lv <= 7'h0a;
		rc(OFS_CSR, 32'h0000_0203, '0, "off");
		@(posedge sys_clk);
		lv <= 7'h25;
		rc(OFS_CSR, 32'h0000_0203, 32'h0000_0201, "reenable");
	endtask : s_rxtx
	task automatic s_mirror();
		for (int k = 0; k < 2; k++)
		begin
			@(posedge sys_clk);
			req <= k ? 5'h0a : 5'h15;
			rc(OFS_CSR, 32'h0088_1818, k ? 32'h0008_1010 : 32'h0088_0808, "mirror");
			rc(OFS_CSR, 32'h0008_0000, '0, "cts clr");
		end
	endtask : s_mirror
	task automatic s_irq();
		wr(OFS_IDR, 32'hffff_ffff);
		wr(OFS_IER, 32'h0000_0020);
		pl(3);
		repeat (2) @(posedge sys_clk);
		#1 chk("irq on", irq, 32'h0000_0001);
		wr(OFS_IDR, 32'h0000_0020);
		repeat (2) @(posedge sys_clk);
		#1 chk("irq off", irq, 32'h0000_0000);
		pl(14);
	endtask : s_irq
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	initial
	begin
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		s_mask();
		s_sticky();
		s_modes();
		s_rxtx();
		s_mirror();
		s_irq();
		print_verdict();
	end
endmodule : tb
